// ===== src/host_link.sv
`timescale 1ns/100ps
interface host_link;
   logic [1:0]       strobe;      // one access per port per cycle
   logic [1:0]       write;
   logic [1:0][3:0]  select;
   logic [1:0][31:0] wdata;
   logic [1:0][31:0] rdata;
   logic [1:0][1:0]  port_state;
   logic [1:0]       irq;

   modport device (input strobe, input write, input select, input wdata,
                   output rdata, output port_state, output irq);
   modport host   (output strobe, output write, output select, output wdata,
                   input rdata, input port_state, input irq);
endinterface

// ===== src/host_port_pkg.sv
package host_port_pkg;
   // register select codes
   localparam logic [3:0] sel_noop      = 4'h0;
   localparam logic [3:0] sel_status    = 4'h1;
   localparam logic [3:0] sel_data      = 4'h2;
   localparam logic [3:0] sel_io        = 4'h3;
   localparam logic [3:0] sel_own_addr  = 4'h4;
   localparam logic [3:0] sel_mask_one  = 4'h5;
   localparam logic [3:0] sel_port_flag = 4'h7;
   localparam logic [3:0] sel_peer_addr = 4'h8;
   localparam logic [3:0] sel_command   = 4'h9;
   localparam logic [3:0] sel_cmd_ext   = 4'hb;
   localparam logic [3:0] sel_mask_two  = 4'hc;
   localparam logic [3:0] sel_status_two = 4'hd;
   localparam logic [3:0] sel_abort     = 4'he;
   localparam logic [3:0] sel_gateway   = 4'hf;

   // port state as seen from the device
   localparam logic [1:0] state_idle  = 2'h0;
   localparam logic [1:0] state_read  = 2'h1;
   localparam logic [1:0] state_write = 2'h2;

   // first status register layout, plus the command register own bit
   localparam int         pos_cmd_done   = 31;
   localparam int         pos_ctrl_free  = 30;
   localparam int         pos_host_err   = 29;
   localparam int         pos_int_err    = 28;
   localparam int         pos_overrun_lo = 26;
   localparam int         pos_port_err_lo = 24;
   localparam int         pos_ring_err_lo = 16;
   localparam logic [31:0] sticky_mask   = 32'h1f3f_0000;
   localparam int         pos_cmd_own    = 31;

   // address steps and reset values
   localparam logic [31:0] step_narrow   = 32'h0000_0004;
   localparam logic [31:0] step_wide     = 32'h0000_0008;
   localparam logic [31:0] reg_reset     = 32'h0000_0000;
endpackage

// ===== src/link_master.sv
`timescale 1ns/100ps
// host end: turns a plain register port into per-port link accesses
module link_master
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   host_link.host           link,
   input  wire logic [4:0]  address,
   input  wire logic [31:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output logic [31:0]      read_data,
   output logic             refused,
   output logic [1:0]       port_irq,
   output logic [1:0]       address_valid
);
   logic        port;
   logic [3:0]  code;
   logic        bad;
   logic        go;
   logic        rd_port_q;
   logic [1:0]  st;

   assign port = address[4];
   assign code = address[3:0];
   assign st   = link.port_state[port];
   // data register direction must suit the device's port state
   assign bad  = (code == host_port_pkg::sel_data)
               & ((read_strobe & (st == host_port_pkg::state_read))
                | (write_strobe & (st == host_port_pkg::state_write)));
   assign go   = (write_strobe | read_strobe) & ~bad;
   assign refused = (write_strobe | read_strobe) & bad;

   // one access driven straight onto the chosen port
   assign link.strobe = go ? (port ? 2'h2 : 2'h1) : 2'h0;
   assign link.write  = write_strobe ? 2'h3 : 2'h0;
   assign link.select = {code, code};
   // commands always go out with the own bit set
   assign link.wdata  = (code == host_port_pkg::sel_command)
                      ? {2{write_data | (32'h1 << host_port_pkg::pos_cmd_own)}}
                      : {2{write_data}};

   // address is only trusted while the port requests something
   assign address_valid[0] = link.port_state[0] != host_port_pkg::state_idle;
   assign address_valid[1] = link.port_state[1] != host_port_pkg::state_idle;
   assign port_irq = link.irq;

   // remember which port answers the next cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rd_port_q <= 1'b0;
      else if (read_strobe)
         rd_port_q <= port;
   end

   assign read_data = link.rdata[rd_port_q];
endmodule // link_master

// ===== src/port_engine.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module port_engine
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   host_link.device          link,
   input  wire logic [1:0][1:0]  port_state_in,
   input  wire logic         wide_mode,
   input  wire logic [1:0]   ring_mode,
   input  wire logic [1:0]   local_mode,
   input  wire logic [31:0]  local_mask,
   input  wire logic [31:0]  ring_base,
   input  wire logic [31:0]  ring_length_limit,
   input  wire logic [1:0]   addr_load,
   input  wire logic [1:0][31:0] addr_load_value,
   input  wire logic [1:0]   entry_not_owned,
   input  wire logic [1:0]   entry_error,
   input  wire logic [1:0]   rx_load,
   input  wire logic [1:0][31:0] rx_value,
   input  wire logic [1:0]   cmd_complete,
   input  wire logic [1:0][31:0] cmd_indication,
   input  wire logic [1:0]   control_register_free_flag,
   input  wire logic [1:0]   host_parity_error_event,
   input  wire logic         internal_error_event,
   input  wire logic [1:0]   receive_overrun_event,
   input  wire logic [1:0]   port_error_event,
   input  wire logic [5:0]   ring_error_event,
   input  wire logic [1:0][31:0] gateway_rdata,
   output logic [1:0]        tx_valid,
   output logic [63:0]       tx_wide_value,
   output logic [1:0][31:0]  command_value,
   output logic [1:0]        command_valid,
   output logic [1:0]        gateway_write,
   output logic [1:0][31:0]  gateway_wdata,
   output logic [1:0]        abort_pulse,
   output logic [1:0][31:0]  own_address_generator
);
   // next address: ring wrap, local wrap, or plain step
   function automatic logic [31:0] next_addr(input logic [31:0] cur, input logic [31:0] step,
                                             input logic ring, input logic local_sel,
                                             input logic [31:0] lmask, input logic [31:0] base,
                                             input logic [31:0] limit);
      logic [31:0] raw;
      raw = cur + step;
      if (ring)
      begin
         next_addr = (raw >= base + limit) ? base : raw;
      end
      else if (local_sel)
      begin
         next_addr = (cur & ~lmask) | (raw & lmask);
      end
      else
      begin
         next_addr = raw;
      end
   endfunction

   logic [31:0]      sticky_q;
   logic [31:0]      sticky_set;
   logic [31:0]      sticky_clr;
   logic [1:0][31:0] data_w;
   logic [1:0][31:0] status_view;
   logic [1:0]       data_ok;
   logic [1:0][31:0] mask_one_w;

   // shared sticky events gathered at their documented positions
   assign sticky_set = {3'h0, internal_error_event, receive_overrun_event, port_error_event,
                        2'h0, ring_error_event, 16'h0000};
   assign sticky_clr = ((link.strobe[0] & link.write[0] & (link.select[0] == host_port_pkg::sel_status))
                        ? link.wdata[0] : 32'h0000_0000)
                     | ((link.strobe[1] & link.write[1] & (link.select[1] == host_port_pkg::sel_status))
                        ? link.wdata[1] : 32'h0000_0000);

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         sticky_q <= host_port_pkg::reg_reset;
      else
         sticky_q <= ((sticky_q & ~sticky_clr) | sticky_set) & host_port_pkg::sticky_mask;
   end

   assign tx_wide_value = {data_w[0], data_w[1]};
   assign link.port_state = port_state_in;

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         logic [31:0] data_q;
         logic [31:0] addr_q;
         logic [31:0] cmd_q;
         logic [31:0] io_q;
         logic [31:0] ext_q;
         logic [31:0] mask_one_q;
         logic [31:0] mask_two_q;
         logic [31:0] rdata_q;
         logic [31:0] rdata_d;
         logic        cdn_q;
         logic        her_q;
         logic        tx_valid_q;
         logic        cmd_valid_q;
         logic        gw_q;
         logic [31:0] gw_data_q;
         logic        abort_q;
         logic        wr;
         logic        rd;
         logic        step_own;
         logic        hold;
         logic [31:0] peer_addr;

         assign wr = link.strobe[p] & link.write[p];
         assign rd = link.strobe[p] & ~link.write[p];
         // a data access counts only in the state that permits it
         assign data_ok[p] = (link.select[p] == host_port_pkg::sel_data)
                           & ((wr & (port_state_in[p] == host_port_pkg::state_read))
                            | (rd & (port_state_in[p] == host_port_pkg::state_write)));
         // in wide mode the first generator serves both ports
         assign step_own = (p == 0) ? (data_ok[0] | (wide_mode & data_ok[1])) : (data_ok[1] & ~wide_mode);
         assign hold = ring_mode[p] & (entry_not_owned[p] | entry_error[p]);
         assign data_w[p] = data_q;
         assign mask_one_w[p] = mask_one_q;
         assign status_view[p] = sticky_q | {cdn_q, control_register_free_flag[p], her_q, 29'h0};
         assign own_address_generator[p] = (wide_mode && p == 1) ? g_port[0].addr_q : addr_q;
         assign peer_addr = (p == 0) ? g_port[1].addr_q : g_port[0].addr_q;

         // read data mux, registered one cycle after the strobe
         always_comb
         begin
            unique case (link.select[p])
               host_port_pkg::sel_status:     rdata_d = status_view[p];
               host_port_pkg::sel_data:       rdata_d = data_q;
               host_port_pkg::sel_io:         rdata_d = io_q;
               host_port_pkg::sel_own_addr:   rdata_d = own_address_generator[p];
               host_port_pkg::sel_mask_one:   rdata_d = mask_one_q;
               host_port_pkg::sel_port_flag:  rdata_d = {30'h0, port_state_in[p]};
               host_port_pkg::sel_peer_addr:  rdata_d = peer_addr;
               host_port_pkg::sel_command:    rdata_d = cmd_q;
               host_port_pkg::sel_cmd_ext:    rdata_d = ext_q;
               host_port_pkg::sel_mask_two:   rdata_d = mask_two_q;
               host_port_pkg::sel_gateway:    rdata_d = gateway_rdata[p];
               default:                       rdata_d = 32'h0000_0000;
            endcase
         end

         // address generator: loads, steps, holds
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               addr_q <= host_port_pkg::reg_reset;
            else if (addr_load[p])
               addr_q <= addr_load_value[p];
            else if (step_own && !hold)
               addr_q <= next_addr(addr_q, wide_mode ? host_port_pkg::step_wide : host_port_pkg::step_narrow,
                                   ring_mode[p], local_mode[p], local_mask, ring_base, ring_length_limit);
         end

         // data register: host fills in read state, device fills in write state
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               data_q <= host_port_pkg::reg_reset;
            else if (wr && data_ok[p])
               data_q <= link.wdata[p];
            else if (rx_load[p])
               data_q <= rx_value[p];
         end

         // command done: completion wins over a same-cycle command write
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cdn_q <= 1'b0;
               cmd_q <= host_port_pkg::reg_reset;
            end
            else if (cmd_complete[p])
            begin
               cdn_q <= 1'b1;
               cmd_q <= cmd_indication[p] & ~(32'h1 << host_port_pkg::pos_cmd_own);
            end
            else if (wr && link.select[p] == host_port_pkg::sel_command)
            begin
               cdn_q <= cdn_q & ~link.wdata[p][host_port_pkg::pos_cmd_own];
               cmd_q <= link.wdata[p];
            end
         end

         // per-port host error, sticky
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               her_q <= 1'b0;
            else
               her_q <= host_parity_error_event[p] | (her_q & ~(wr && link.select[p] == host_port_pkg::sel_status
                        && link.wdata[p][host_port_pkg::pos_host_err]));
         end

         // plain read/write registers; other codes write nothing
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               io_q       <= host_port_pkg::reg_reset;
               ext_q      <= host_port_pkg::reg_reset;
               mask_one_q <= host_port_pkg::reg_reset;
               mask_two_q <= host_port_pkg::reg_reset;
            end
            else if (wr)
            begin
               unique case (link.select[p])
                  host_port_pkg::sel_io:        io_q       <= link.wdata[p];
                  host_port_pkg::sel_cmd_ext:   ext_q      <= link.wdata[p];
                  host_port_pkg::sel_mask_one:  mask_one_q <= link.wdata[p];
                  host_port_pkg::sel_mask_two:  mask_two_q <= link.wdata[p];
                  default:                      io_q       <= io_q;
               endcase
            end
         end

         // pulses and read data toward both sides
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               rdata_q     <= host_port_pkg::reg_reset;
               tx_valid_q  <= 1'b0;
               cmd_valid_q <= 1'b0;
               gw_q        <= 1'b0;
               gw_data_q   <= host_port_pkg::reg_reset;
               abort_q     <= 1'b0;
            end
            else
            begin
               rdata_q     <= rd ? rdata_d : rdata_q;
               tx_valid_q  <= wr & data_ok[p];
               cmd_valid_q <= wr & (link.select[p] == host_port_pkg::sel_command);
               gw_q        <= wr & (link.select[p] == host_port_pkg::sel_gateway);
               gw_data_q   <= (wr && link.select[p] == host_port_pkg::sel_gateway) ? link.wdata[p] : gw_data_q;
               abort_q     <= link.strobe[p] & (link.select[p] == host_port_pkg::sel_abort);
            end
         end

         assign link.rdata[p]    = rdata_q;
         assign tx_valid[p]      = tx_valid_q;
         assign command_value[p] = cmd_q;
         assign command_valid[p] = cmd_valid_q;
         assign gateway_write[p] = gw_q;
         assign gateway_wdata[p] = gw_data_q;
         assign abort_pulse[p]   = abort_q;
         assign link.irq[p]      = |(status_view[p] & mask_one_w[p]);
      end
   endgenerate
endmodule // port_engine

// ===== tb/host_link_checker.sv
`timescale 1ns/100ps
// watches the link that joins the host end to the device end
module host_link_checker
(
   input wire logic             clock,
   input wire logic             rst_n,
   input wire logic [1:0]       strobe,
   input wire logic [1:0]       write,
   input wire logic [1:0][3:0]  select,
   input wire logic [1:0][31:0] wdata,
   input wire logic [1:0][31:0] rdata,
   input wire logic [1:0][1:0]  port_state,
   input wire logic [1:0]       irq
);
   logic [31:0] mask_q;
   logic [31:0] mask_d;
   wire         rd0 = strobe[0] && !write[0];
   wire         st0 = rd0 && select[0] == host_port_pkg::sel_status;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // shadow of the first port's mask, so irq can be tied to a status read
   assign mask_d = (strobe[0] && write[0] && select[0] == host_port_pkg::sel_mask_one) ? wdata[0] : mask_q;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= '0;
      else
         mask_q <= mask_d;
   end

   property p_single_access;
      $onehot0(strobe);
   endproperty
   a_single_access: assert property (p_single_access) else $error("both ports strobed");
   property p_no_read_in_read;
      strobe[1] && !write[1] && select[1] == host_port_pkg::sel_data |-> port_state[1] != host_port_pkg::state_read;
   endproperty
   a_no_read_in_read: assert property (p_no_read_in_read) else $error("data read in read state");
   property p_no_write_in_write;
      strobe[1] && write[1] && select[1] == host_port_pkg::sel_data |-> port_state[1] != host_port_pkg::state_write;
   endproperty
   a_no_write_in_write: assert property (p_no_write_in_write) else $error("data write in write state");
   property p_status_layout;
      st0 |=> rdata[0][23:22] == 2'h0 && rdata[0][15:0] == 16'h0;
   endproperty
   a_status_layout: assert property (p_status_layout) else $error("unused status bits set");
   property p_reserved_zero;
      rd0 && (select[0] == 4'h6 || select[0] == 4'ha) |=> rdata[0] == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");
   property p_rdata_holds;
      !rd0 |=> $stable(rdata[0]);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read");
   property p_irq_matches;
      st0 |=> ((rdata[0] & mask_q) != 32'h0) == $past(irq[0]);
   endproperty
   a_irq_matches: assert property (p_irq_matches) else $error("irq disagrees with status and mask");
   property p_cmd_own;
      strobe[0] && write[0] && select[0] == host_port_pkg::sel_command |-> wdata[0][host_port_pkg::pos_cmd_own];
   endproperty
   a_cmd_own: assert property (p_cmd_own) else $error("command written without own bit");

   // main scenarios
   c_status_read: cover property (st0);
   c_both_irq: cover property (irq == 2'b11);
   c_wide_write: cover property (strobe[1] && write[1] && select[1] == host_port_pkg::sel_data);
endmodule // host_link_checker

// ===== tb/host_register_port_addressing_tb.sv
`timescale 1ns/100ps
module host_register_port_addressing_tb;
   logic            clock;
   logic            rst_n = 1'b0;
   logic [4:0]      address = '0;
   logic [31:0]     write_data = '0;
   logic            write_strobe = 1'b0;
   logic            read_strobe = 1'b0;
   logic [31:0]     read_data;
   logic            refused, last_ref;
   logic [1:0]      port_irq, address_valid, tx_valid, command_valid, gateway_write, abort_pulse;
   logic [63:0]     tx_wide_value;
   logic [1:0][31:0] command_value, gateway_wdata, own_address_generator;
   logic [1:0][1:0] port_state_in = '0;
   logic            wide_mode = 1'b0, internal_error_event = 1'b0;
   logic [1:0]      ring_mode = '0, local_mode = '0, addr_load = '0, entry_not_owned = '0, entry_error = '0;
   logic [1:0]      rx_load = '0, cmd_complete = '0, control_register_free_flag = '0;
   logic [1:0]      host_parity_error_event = '0, receive_overrun_event = '0, port_error_event = '0;
   logic [5:0]      ring_error_event = '0;
   logic [31:0]     local_mask = '0, ring_base = '0, ring_length_limit = '0;
   logic [1:0][31:0] addr_load_value = '0, rx_value = '0, cmd_indication = '0, gateway_rdata = '0;
   logic [4:0]      rw_list [8] = '{5'h03, 5'h05, 5'h0b, 5'h0c, 5'h13, 5'h15, 5'h1b, 5'h1c};
   logic [4:0]      ro_list [9] = '{5'h00, 5'h04, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0d, 5'h14, 5'h18};
   int              n_fail = 0;
   int              tests_run = 0;

   host_link link_if();
   port_engine i_port_engine (.clock(clock), .rst_n(rst_n), .link(link_if), .port_state_in(port_state_in),
      .wide_mode(wide_mode), .ring_mode(ring_mode), .local_mode(local_mode), .local_mask(local_mask),
      .ring_base(ring_base), .ring_length_limit(ring_length_limit), .addr_load(addr_load),
      .addr_load_value(addr_load_value), .entry_not_owned(entry_not_owned), .entry_error(entry_error),
      .rx_load(rx_load), .rx_value(rx_value), .cmd_complete(cmd_complete), .cmd_indication(cmd_indication),
      .control_register_free_flag(control_register_free_flag), .host_parity_error_event(host_parity_error_event),
      .internal_error_event(internal_error_event), .receive_overrun_event(receive_overrun_event),
      .port_error_event(port_error_event), .ring_error_event(ring_error_event), .gateway_rdata(gateway_rdata),
      .tx_valid(tx_valid), .tx_wide_value(tx_wide_value), .command_value(command_value),
      .command_valid(command_valid), .gateway_write(gateway_write), .gateway_wdata(gateway_wdata),
      .abort_pulse(abort_pulse), .own_address_generator(own_address_generator));
   link_master i_link_master (.clock(clock), .rst_n(rst_n), .link(link_if), .address(address),
      .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .refused(refused), .port_irq(port_irq), .address_valid(address_valid));
   host_link_checker i_host_link_checker (.clock(clock), .rst_n(rst_n), .strobe(link_if.strobe),
      .write(link_if.write), .select(link_if.select), .wdata(link_if.wdata), .rdata(link_if.rdata),
      .port_state(link_if.port_state), .irq(link_if.irq));

   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one register access; refused is combinational, so it is caught mid-cycle
   task automatic access(input logic [4:0] a, input logic wr, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= wr;
      read_strobe <= !wr;
      #1 last_ref = refused;
      @(posedge clock);
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      access(a, 1'b1, d);
   endtask
   task automatic rd(input string name, input logic [4:0] a, input logic [31:0] exp);
      access(a, 1'b0, 32'h0);
      #1 chk(name, 64'(exp), 64'(read_data));
   endtask
   task automatic load(input int p, input logic [31:0] v);
      @(posedge clock);
      addr_load[p] <= 1'b1;
      addr_load_value[p] <= v;
      @(posedge clock);
      addr_load[p] <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // 125 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // the whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      summarize();
   end
   // main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      chk("address valid idle", 64'h0, 64'(address_valid));
      foreach (rw_list[i]) rd("reset value", rw_list[i], 32'h0);
      rd("status reset", 5'h01, 32'h0);
      $display("test reset done");
      foreach (rw_list[i]) wr(rw_list[i], 32'ha5a5_0000 | 32'(rw_list[i]));
      foreach (ro_list[i]) wr(ro_list[i], 32'hffff_ffff);
      foreach (rw_list[i]) rd("storage", rw_list[i], 32'ha5a5_0000 | 32'(rw_list[i]));
      foreach (ro_list[i]) rd("read only", ro_list[i], 32'h0);
      $display("test registers done");
      @(posedge clock) port_state_in[0] <= host_port_pkg::state_read;
      load(0, 32'h0000_0100);
      rd("port state", 5'h07, 32'(host_port_pkg::state_read));
      wr(5'h02, 32'h1111_1111);
      #1 chk("tx valid", 64'h1, 64'(tx_valid));
      rd("own address", 5'h04, 32'h100 + host_port_pkg::step_narrow);
      rd("own address again", 5'h04, 32'h0000_0104);
      rd("peer address", 5'h18, 32'h0000_0104);
      access(5'h02, 1'b0, 32'h0);
      chk("read refused", 64'h1, 64'(last_ref));
      rd("address after refusal", 5'h04, 32'h0000_0104);
      chk("address valid", 64'h1, 64'(address_valid[0]));
      @(posedge clock);
      ring_mode[0] <= 1'b1;
      ring_base <= 32'h0000_0100;
      ring_length_limit <= 32'h0000_0008;
      wr(5'h02, 32'h0);
      rd("ring wrap", 5'h04, 32'h0000_0100);
      @(posedge clock) entry_not_owned[0] <= 1'b1;
      wr(5'h02, 32'h0);
      rd("unowned hold", 5'h04, 32'h0000_0100);
      @(posedge clock) {entry_not_owned[0], entry_error[0]} <= 2'b01;
      wr(5'h02, 32'h0);
      rd("error hold", 5'h04, 32'h0000_0100);
      @(posedge clock) {entry_error[0], ring_mode[0], local_mode[0]} <= 3'b001;
      local_mask <= 32'h0000_000f;
      load(0, 32'h0000_021c);
      wr(5'h02, 32'h0);
      rd("local wrap", 5'h04, 32'h0000_0210);
      @(posedge clock) {local_mode[0], wide_mode} <= 2'b01;
      port_state_in[1] <= host_port_pkg::state_read;
      load(0, 32'h0000_0040);
      wr(5'h02, 32'hdead_beef);
      rd("wide step", 5'h04, 32'h40 + host_port_pkg::step_wide);
      rd("wide via second port", 5'h14, 32'h0000_0048);
      wr(5'h12, 32'h0123_4567);
      #1 chk("wide word", 64'hdead_beef_0123_4567, tx_wide_value);
      chk("address out", 64'h0000_0050_0000_0050, own_address_generator);
      $display("test address done");
      @(posedge clock) wide_mode <= 1'b0;
      port_state_in[1] <= host_port_pkg::state_write;
      rx_load[1] <= 1'b1;
      rx_value[1] <= 32'h0bad_cafe;
      @(posedge clock) rx_load[1] <= 1'b0;
      rd("receive data", 5'h12, 32'h0bad_cafe);
      access(5'h12, 1'b1, 32'h0);
      chk("write refused", 64'h1, 64'(last_ref));
      $display("test receive done");
      wr(5'h09, 32'h0000_0055);
      #1 chk("command valid", 64'h1, 64'(command_valid));
      rd("command own", 5'h09, 32'h8000_0055);
      rd("done clear", 5'h01, 32'h0);
      @(posedge clock) cmd_complete[0] <= 1'b1;
      cmd_indication[0] <= 32'h8000_00aa;
      @(posedge clock) cmd_complete[0] <= 1'b0;
      rd("indication", 5'h09, 32'h0000_00aa);
      chk("command out", 64'h0000_00aa, 64'(command_value[0]));
      rd("done set", 5'h01, 32'h8000_0000);
      rd("done other port", 5'h11, 32'h0);
      wr(5'h01, 32'hffff_ffff);
      rd("done kept", 5'h01, 32'h8000_0000);
      @(posedge clock) control_register_free_flag[0] <= 1'b1;
      {host_parity_error_event[0], internal_error_event, receive_overrun_event, port_error_event} <= 6'h3f;
      ring_error_event <= 6'h3f;
      @(posedge clock) {host_parity_error_event, internal_error_event, receive_overrun_event} <= '0;
      {port_error_event, ring_error_event} <= '0;
      rd("sticky first", 5'h01, 32'hff3f_0000);
      rd("sticky second", 5'h11, 32'h1f3f_0000);
      wr(5'h11, 32'h1000_0000);
      rd("one cleared", 5'h01, 32'hef3f_0000);
      wr(5'h01, 32'hffff_ffff);
      rd("live kept", 5'h01, 32'hc000_0000);
      wr(5'h05, 32'h1000_0000);
      wr(5'h15, 32'h1000_0000);
      #1 chk("irq quiet", 64'h0, 64'(port_irq));
      @(posedge clock) internal_error_event <= 1'b1;
      @(posedge clock) internal_error_event <= 1'b0;
      #1 chk("irq both", 64'h3, 64'(port_irq));
      wr(5'h01, 32'h1000_0000);
      #1 chk("irq cleared", 64'h0, 64'(port_irq));
      $display("test status done");
      wr(5'h0e, 32'h0);
      #1 chk("abort first", 64'h1, 64'(abort_pulse));
      wr(5'h1e, 32'h0);
      #1 chk("abort second", 64'h2, 64'(abort_pulse));
      wr(5'h0f, 32'h0000_0123);
      #1 chk("gateway write", 64'h1_0000_0123, {31'h0, gateway_write[0], gateway_wdata[0]});
      @(posedge clock) gateway_rdata[1] <= 32'h0000_0456;
      rd("gateway read", 5'h1f, 32'h0000_0456);
      $display("test control done");
      summarize();
   end
endmodule // host_register_port_addressing_tb
